// file: rhsp_pkg.sv
// Purpose: shared constants and types for the serial host port
// Assumes: 10 MHz pclk, APB register access
// Notes: offsets are byte addresses
package rhsp_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;

    // =========================================================
    // register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_TXD = 8'h08;
    localparam logic [7:0] ADDR_RXD = 8'h0C;
    localparam logic [7:0] ADDR_CMD = 8'h10;

    // =========================================================
    // control register fields
    localparam int CTRL_BAUD_LSB = 0;
    localparam int CTRL_FMT_LSB = 4;
    localparam int CTRL_FLOW_LSB = 8;
    localparam int CTRL_IFSEL_BIT = 12;

    // command register bits (write one to act)
    localparam int CMD_LOCAL_BIT = 0;
    localparam int CMD_LOCKOUT_BIT = 1;
    localparam int CMD_BRKACK_BIT = 2;

    // =========================================================
    // enumerations
    typedef enum logic [3:0] {
        BAUD_300 = 4'h0, BAUD_600 = 4'h1, BAUD_1200 = 4'h2, BAUD_2400 = 4'h3,
        BAUD_4800 = 4'h4, BAUD_9600 = 4'h5, BAUD_19200 = 4'h6, BAUD_38400 = 4'h7,
        BAUD_57600 = 4'h8, BAUD_115200 = 4'h9
    } rhsp_baud_t;

    typedef enum logic [1:0] {
        FMT_NONE8 = 2'h0,
        FMT_EVEN7 = 2'h1,
        FMT_ODD7 = 2'h2
    } rhsp_fmt_t;

    typedef enum logic [2:0] {
        FLOW_NONE = 3'h0,
        FLOW_DTRDSR = 3'h1,
        FLOW_MODEM = 3'h2,
        FLOW_RTSCTS = 3'h3,
        FLOW_XONXOFF = 3'h4
    } rhsp_flow_t;

    typedef enum logic [1:0] {
        SER_IDLE = 2'h0,
        SER_START = 2'h1,
        SER_BITS = 2'h2,
        SER_STOP = 2'h3
    } rhsp_ser_t;

    localparam rhsp_baud_t RST_BAUD = BAUD_57600;
    localparam rhsp_fmt_t RST_FMT = FMT_NONE8;
    localparam rhsp_flow_t RST_FLOW = FLOW_DTRDSR;
    localparam logic RST_IFSEL = 1'b0;

    localparam logic [7:0] XOFF_CHAR = 8'h13;
    localparam logic [7:0] XON_CHAR = 8'h11;
    localparam int unsigned RX_NEAR_FULL = 100;
    localparam int unsigned RX_DEPTH = 128;
    localparam int unsigned TX_DEPTH = 32;
    localparam int unsigned OVS = 16;

    // modem line group
    typedef struct packed {
        logic dtr;
        logic rts;
    } rhsp_modem_out_t;

    // oversample divider per rate, rounded down to whole cycles
    function automatic logic [11:0] baud_div(input rhsp_baud_t b);
        int unsigned r;
        case (b)
            BAUD_300: r = 300;
            BAUD_600: r = 600;
            BAUD_1200: r = 1200;
            BAUD_2400: r = 2400;
            BAUD_4800: r = 4800;
            BAUD_9600: r = 9600;
            BAUD_19200: r = 19200;
            BAUD_38400: r = 38400;
            BAUD_57600: r = 57600;
            BAUD_115200: r = 115200;
            default: r = 57600;
        endcase
        baud_div = 12'(CLK_HZ / (r * OVS));
    endfunction

endpackage

// file: rhsp_fifo.sv
// Purpose: synchronous FIFO with valid/ready on both sides
// Assumes: single clock
// Notes: depth is a power of two
module rhsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic flush, // drop all contents
    input wire logic [WIDTH-1:0] in_data, // write data
    input wire logic in_valid, // write request
    output logic in_ready, // space available
    output logic [WIDTH-1:0] out_data, // head word
    output logic out_valid, // head valid
    input wire logic out_ready, // consume head
    output logic [$clog2(DEPTH):0] level // words held
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("rhsp_fifo: DEPTH must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg;
    logic [AW:0] rd_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign level = wr_reg - rd_reg;
    assign in_ready = level != (AW+1)'(DEPTH);
    assign out_valid = level != '0;
    assign out_data = mem[rd_reg[AW-1:0]];

    always_ff @(posedge pclk) begin
        if (push) mem[wr_reg[AW-1:0]] <= in_data;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else if (flush) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (push) wr_reg <= wr_reg + 1'b1;
            if (pop) rd_reg <= rd_reg + 1'b1;
        end
    end
endmodule // rhsp_fifo

// file: rhsp_port.sv
// Purpose: RS-232 host serial port with APB registers
// Assumes: 10 MHz pclk, rxd/dsr/cts are asynchronous pins
// Notes: 16x oversampled receiver, fixed one start and one stop bit

// Notes on behaviour
// - ten selectable line rates, 57600 after reset; host uses the same
// - format 8N, 7E or 7O, default 8N; host must match
// - exactly one start and one stop bit, fixed both directions
// - frame is start, data, parity only when chosen, stop
// - five flow modes, DTR/DSR after reset
// - DTR/DSR mode sends only while DSR asserted
// - DTR/DSR mode drops DTR near 100 buffered characters, restores later
// - modem mode: DTR when serial selected, RTS when ready to receive
// - RTS/CTS mode sends only with CTS, drops RTS near 100 characters
// - XON/XOFF mode pauses on 13h, resumes on 11h
// - break on receive line aborts work and flushes pending output
// - one remote interface active, parallel bus selected by default
// - local command enables every front-panel key
// - lockout command enters remote mode, ignores front-panel keys while serial is selected
module rhsp_port (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic rxd, // serial receive pin
    output logic txd, // serial transmit pin
    input wire logic dsr, // data set ready pin, high true
    input wire logic cts, // clear to send pin, high true
    output logic dtr, // data terminal ready, high true
    output logic rts, // request to send, high true
    output logic serial_selected, // serial is the active remote interface
    output logic keys_locked, // front-panel keys ignored
    output logic abort_pulse // one-cycle abort on break
);
    // =========================================================
    // pin synchronisers
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 3'h7;
            sync2_reg <= 3'h7;
        end else begin
            sync1_reg <= {cts, dsr, rxd};
            sync2_reg <= sync1_reg;
        end
    end
    wire rx_s = sync2_reg[0];
    wire dsr_s = sync2_reg[1];
    wire cts_s = sync2_reg[2];

    // =========================================================
    // control registers
    rhsp_pkg::rhsp_baud_t baud_reg;
    rhsp_pkg::rhsp_fmt_t fmt_reg;
    rhsp_pkg::rhsp_flow_t flow_reg;
    logic ifsel_reg;
    logic locked_reg;
    logic brk_seen_reg;
    logic xoff_reg;

    wire wr_acc = psel && penable && pwrite && pready;
    wire rd_acc = psel && penable && !pwrite && pready;
    wire sel_ctrl = paddr == rhsp_pkg::ADDR_CTRL;
    wire sel_stat = paddr == rhsp_pkg::ADDR_STAT;
    wire sel_txd = paddr == rhsp_pkg::ADDR_TXD;
    wire sel_rxd = paddr == rhsp_pkg::ADDR_RXD;
    wire sel_cmd = paddr == rhsp_pkg::ADDR_CMD;
    wire mapped = sel_ctrl || sel_stat || sel_txd || sel_rxd || sel_cmd;
    wire [3:0] baud_w = pwdata[rhsp_pkg::CTRL_BAUD_LSB +: 4];
    wire [1:0] fmt_w = pwdata[rhsp_pkg::CTRL_FMT_LSB +: 2];
    wire [2:0] flow_w = pwdata[rhsp_pkg::CTRL_FLOW_LSB +: 3];
    wire baud_ok = baud_w <= 4'h9;
    wire fmt_ok = fmt_w <= 2'h2;
    wire flow_ok = flow_w <= 3'h4;

    // =========================================================
    // fifos
    logic tx_in_ready;
    logic [7:0] tx_head;
    logic tx_head_valid;
    logic tx_pop;
    logic [5:0] tx_level;
    logic [7:0] rx_push_data;
    logic rx_push;
    logic rx_in_ready;
    logic [7:0] rx_head;
    logic rx_head_valid;
    logic [7:0] rx_level;
    logic brk_event;

    wire tx_push = wr_acc && sel_txd && tx_in_ready;
    wire rx_pop = rd_acc && sel_rxd && rx_head_valid;
    wire flush_tx = brk_event;

    rhsp_fifo #(.WIDTH(8), .DEPTH(rhsp_pkg::TX_DEPTH)) u_txq (
        .pclk(pclk),
        .presetn(presetn),
        .flush(flush_tx),
        .in_data(pwdata[7:0]),
        .in_valid(tx_push),
        .in_ready(tx_in_ready),
        .out_data(tx_head),
        .out_valid(tx_head_valid),
        .out_ready(tx_pop),
        .level(tx_level)
    );

    rhsp_fifo #(.WIDTH(8), .DEPTH(rhsp_pkg::RX_DEPTH)) u_rxq (
        .pclk(pclk),
        .presetn(presetn),
        .flush(1'b0),
        .in_data(rx_push_data),
        .in_valid(rx_push),
        .in_ready(rx_in_ready),
        .out_data(rx_head),
        .out_valid(rx_head_valid),
        .out_ready(rx_pop),
        .level(rx_level)
    );

    // =========================================================
    // oversample tick
    logic [11:0] div_reg;
    logic tick;
    wire [11:0] div_max = rhsp_pkg::baud_div(baud_reg);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= '0;
            tick <= 1'b0;
        end else begin
            tick <= div_reg == 12'h000;
            div_reg <= (div_reg == 12'h000) ? div_max - 12'h001 : div_reg - 12'h001;
        end
    end

    function automatic logic [3:0] frame_bits(input rhsp_pkg::rhsp_fmt_t f);
        frame_bits = (f == rhsp_pkg::FMT_NONE8) ? 4'h8 : 4'h8;
    endfunction
    function automatic logic par_bit(input logic [6:0] d, input rhsp_pkg::rhsp_fmt_t f);
        par_bit = (^d) ^ (f == rhsp_pkg::FMT_ODD7);
    endfunction

    // =========================================================
    // flow gate for transmit
    wire flow_dsr = flow_reg == rhsp_pkg::FLOW_DTRDSR;
    wire flow_cts = flow_reg == rhsp_pkg::FLOW_RTSCTS || flow_reg == rhsp_pkg::FLOW_MODEM;
    wire tx_allowed = !(flow_dsr && !dsr_s)
        && !(flow_cts && !cts_s)
        && !(flow_reg == rhsp_pkg::FLOW_XONXOFF && xoff_reg);

    // =========================================================
    // transmitter
    rhsp_pkg::rhsp_ser_t tx_st;
    logic [3:0] tx_os;
    logic [3:0] tx_idx;
    logic [7:0] tx_sh;
    logic [7:0] tx_frame;
    assign tx_frame = (fmt_reg == rhsp_pkg::FMT_NONE8) ? tx_head
        : {par_bit(tx_head[6:0], fmt_reg), tx_head[6:0]};
    assign tx_pop = (tx_st == rhsp_pkg::SER_IDLE) && tick && tx_head_valid && tx_allowed && !flush_tx;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st <= rhsp_pkg::SER_IDLE;
            tx_os <= '0;
            tx_idx <= '0;
            tx_sh <= '0;
            txd <= 1'b1;
        end else if (tick) begin
            tx_os <= tx_os + 4'h1;
            case (tx_st)
                rhsp_pkg::SER_IDLE: begin
                    txd <= 1'b1;
                    if (tx_pop) begin
                        tx_sh <= tx_frame;
                        tx_os <= 4'h0;
                        txd <= 1'b0;
                        tx_st <= rhsp_pkg::SER_START;
                    end
                end
                rhsp_pkg::SER_START: begin
                    if (tx_os == 4'hF) begin
                        txd <= tx_sh[0];
                        tx_sh <= {1'b0, tx_sh[7:1]};
                        tx_idx <= 4'h1;
                        tx_st <= rhsp_pkg::SER_BITS;
                    end
                end
                rhsp_pkg::SER_BITS: begin
                    if (tx_os == 4'hF) begin
                        if (tx_idx == frame_bits(fmt_reg)) begin
                            txd <= 1'b1;
                            tx_st <= rhsp_pkg::SER_STOP;
                        end else begin
                            txd <= tx_sh[0];
                            tx_sh <= {1'b0, tx_sh[7:1]};
                            tx_idx <= tx_idx + 4'h1;
                        end
                    end
                end
                rhsp_pkg::SER_STOP: begin
                    if (tx_os == 4'hF) tx_st <= rhsp_pkg::SER_IDLE;
                end
                default: tx_st <= rhsp_pkg::SER_IDLE;
            endcase
        end
    end

    // =========================================================
    // receiver, sampled at bit centre
    rhsp_pkg::rhsp_ser_t rx_st;
    logic [3:0] rx_os;
    logic [3:0] rx_idx;
    logic [7:0] rx_sh;
    logic rx_allzero;
    logic rx_done;
    wire [7:0] rx_char = (fmt_reg == rhsp_pkg::FMT_NONE8) ? rx_sh : {1'b0, rx_sh[6:0]};
    wire rx_mid = tick && rx_os == 4'h7;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st <= rhsp_pkg::SER_IDLE;
            rx_os <= '0;
            rx_idx <= '0;
            rx_sh <= '0;
            rx_allzero <= 1'b0;
            rx_done <= 1'b0;
            brk_event <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            brk_event <= 1'b0;
            if (tick) begin
                rx_os <= rx_os + 4'h1;
                case (rx_st)
                    rhsp_pkg::SER_IDLE: begin
                        rx_os <= 4'h0;
                        if (!rx_s) rx_st <= rhsp_pkg::SER_START;
                    end
                    rhsp_pkg::SER_START: begin
                        if (rx_mid) begin
                            rx_st <= rx_s ? rhsp_pkg::SER_IDLE : rhsp_pkg::SER_BITS;
                            rx_idx <= 4'h0;
                            rx_allzero <= 1'b1;
                        end
                    end
                    rhsp_pkg::SER_BITS: begin
                        if (rx_mid) begin
                            rx_sh <= {rx_s, rx_sh[7:1]};
                            rx_allzero <= rx_allzero && !rx_s;
                            rx_idx <= rx_idx + 4'h1;
                            if (rx_idx == frame_bits(fmt_reg) - 4'h1) rx_st <= rhsp_pkg::SER_STOP;
                        end
                    end
                    rhsp_pkg::SER_STOP: begin
                        if (rx_mid) begin
                            rx_st <= rhsp_pkg::SER_IDLE;
                            if (rx_s) rx_done <= 1'b1;
                            else if (rx_allzero) brk_event <= 1'b1;
                        end
                    end
                    default: rx_st <= rhsp_pkg::SER_IDLE;
                endcase
            end
        end
    end

    wire is_xoff = rx_char == rhsp_pkg::XOFF_CHAR;
    wire is_xon = rx_char == rhsp_pkg::XON_CHAR;
    wire xon_mode = flow_reg == rhsp_pkg::FLOW_XONXOFF;
    assign rx_push_data = rx_char;
    assign rx_push = rx_done && rx_in_ready && !(xon_mode && (is_xoff || is_xon));

    // =========================================================
    // flow state, modem outputs
    wire rx_nearfull = rx_level >= 8'(rhsp_pkg::RX_NEAR_FULL);
    rhsp_pkg::rhsp_modem_out_t modem_next;
    assign modem_next.dtr = (flow_reg == rhsp_pkg::FLOW_DTRDSR) ? !rx_nearfull
        : (flow_reg == rhsp_pkg::FLOW_MODEM) ? ifsel_reg : 1'b1;
    assign modem_next.rts = (flow_reg == rhsp_pkg::FLOW_RTSCTS || flow_reg == rhsp_pkg::FLOW_MODEM)
        ? !rx_nearfull : 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dtr <= 1'b0;
            rts <= 1'b0;
            xoff_reg <= 1'b0;
        end else begin
            dtr <= modem_next.dtr;
            rts <= modem_next.rts;
            if (!xon_mode || brk_event) xoff_reg <= 1'b0;
            else if (rx_done && is_xoff) xoff_reg <= 1'b1;
            else if (rx_done && is_xon) xoff_reg <= 1'b0;
        end
    end

    // =========================================================
    // apb register writes and commands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_reg <= rhsp_pkg::RST_BAUD;
            fmt_reg <= rhsp_pkg::RST_FMT;
            flow_reg <= rhsp_pkg::RST_FLOW;
            ifsel_reg <= rhsp_pkg::RST_IFSEL;
            locked_reg <= 1'b0;
            brk_seen_reg <= 1'b0;
            abort_pulse <= 1'b0;
        end else begin
            abort_pulse <= brk_event;
            if (wr_acc && sel_ctrl) begin
                if (baud_ok) baud_reg <= rhsp_pkg::rhsp_baud_t'(baud_w);
                if (fmt_ok) fmt_reg <= rhsp_pkg::rhsp_fmt_t'(fmt_w);
                if (flow_ok) flow_reg <= rhsp_pkg::rhsp_flow_t'(flow_w);
                ifsel_reg <= pwdata[rhsp_pkg::CTRL_IFSEL_BIT];
            end
            if (wr_acc && sel_cmd && pwdata[rhsp_pkg::CMD_LOCAL_BIT]) locked_reg <= 1'b0;
            else if (wr_acc && sel_cmd && pwdata[rhsp_pkg::CMD_LOCKOUT_BIT]) locked_reg <= 1'b1;
            if (brk_event) brk_seen_reg <= 1'b1;
            else if (wr_acc && sel_cmd && pwdata[rhsp_pkg::CMD_BRKACK_BIT]) brk_seen_reg <= 1'b0;
        end
    end

    // =========================================================
    // apb read path, one wait state
    wire [31:0] ctrl_rd = {19'h0, ifsel_reg, 1'b0, flow_reg, 2'h0, fmt_reg, baud_reg};
    wire [31:0] stat_rd = {8'h0, rx_level, 2'h0, tx_level, 1'b0, locked_reg, brk_seen_reg,
        xoff_reg, cts_s, dsr_s, tx_in_ready, rx_head_valid};
    wire [31:0] rxd_rd = {23'h0, rx_head_valid, rx_head};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_rd : sel_stat ? stat_rd : sel_rxd ? rxd_rd : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            serial_selected <= 1'b0;
            keys_locked <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            prdata <= (psel && penable && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
            pslverr <= psel && penable && !pready && !mapped;
            serial_selected <= ifsel_reg;
            keys_locked <= locked_reg && ifsel_reg;
        end
    end
endmodule // rhsp_port

// file: rhsp_port_chk.sv
// Purpose: concurrent checks on the serial host port pins
// Assumes: control written only with legal field values
// Notes: bound to rhsp_port below
module rhsp_port_chk (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic txd, // serial out
    input wire logic dsr, // data set ready
    input wire logic cts, // clear to send
    input wire logic dtr, // terminal ready
    input wire logic rts, // request to send
    input wire logic serial_selected, // serial active
    input wire logic keys_locked, // keys ignored
    input wire logic abort_pulse // break abort
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int GATE_CYC = 1000;
    logic [12:0] ctrl_q;
    logic [9:0] gate_cnt;
    wire ctrl_wr = psel && penable && pwrite && pready && paddr == rhsp_pkg::ADDR_CTRL;
    wire gate_low = (ctrl_q[10:8] == 3'h1 && !dsr) || (ctrl_q[10:8] == 3'h3 && !cts);
    // =========================================
    // shadow of control and gate-low time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ctrl_q <= 13'h0108;
        else if (ctrl_wr) ctrl_q <= pwdata[12:0] & 13'h173F;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) gate_cnt <= 10'h000;
        else if (!gate_low || ctrl_wr) gate_cnt <= 10'h000;
        else if (gate_cnt != 10'h3FF) gate_cnt <= gate_cnt + 10'h001;
    end
    // =========================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_apb_wait_state: assert property ($rose(psel && penable) |-> !pready ##1 pready)
        else $error("late apb answer");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_unmapped_err: assert property (pready |-> pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0))
        else $error("bad pslverr");
    a_flow_gate: assert property (gate_cnt >= GATE_CYC && ctrl_q[3:0] == 4'h9 |-> txd)
        else $error("sent while gated");
    a_modem_dtr: assert property ($stable(ctrl_q) [*3] ##0 ctrl_q[10:8] == 3'h2 |-> dtr == ctrl_q[12])
        else $error("modem dtr wrong");
    a_sel_level: assert property ($stable(ctrl_q) [*2] |-> serial_selected == ctrl_q[12])
        else $error("bad serial_selected");
    a_abort_once: assert property (abort_pulse |=> !abort_pulse)
        else $error("abort pulse held");
    a_lock_sel: assert property (keys_locked |-> serial_selected || $past(serial_selected))
        else $error("lock without serial");
    a_free_lines: assert property ($stable(ctrl_q) [*3] ##0 ctrl_q[10:8] inside {3'h0, 3'h4} |-> dtr && rts)
        else $error("dtr or rts low");
endmodule // rhsp_port_chk

bind rhsp_port rhsp_port_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .txd, .dsr, .cts, .dtr, .rts, .serial_selected, .keys_locked, .abort_pulse);

// file: rhsp_host_model.sv
// Purpose: host computer on the far end of the serial link
// Assumes: frames of ten bits, same rate as the port
// Notes: received frames queue up raw, start bit first
module rhsp_host_model #(
    parameter int BIT_CYC = 80
) (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, low
    input wire logic txd, // port serial out
    output logic rxd, // port serial in
    output logic dsr, // data set ready
    output logic cts // clear to send
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] got_q [$];
    logic [9:0] rx_frame;
    initial begin
        rxd = 1'b1;
        dsr = 1'b1;
        cts = 1'b1;
    end
    // =========================================
    // send one frame, then mark idle
    task automatic send(input logic [9:0] fr);
        for (int i = 0; i < 10; i++) begin
            rxd <= fr[i];
            repeat (BIT_CYC) @(posedge pclk);
        end
        rxd <= 1'b1;
    endtask
    // =========================================
    // sample a frame at bit middles
    always begin
        @(posedge pclk);
        if (presetn === 1'b1 && txd === 1'b0) begin
            repeat (BIT_CYC / 2) @(posedge pclk);
            for (int i = 0; i < 10; i++) begin
                rx_frame[i] = txd;
                if (i < 9) repeat (BIT_CYC) @(posedge pclk);
            end
            got_q.push_back(rx_frame);
        end
    end
endmodule // rhsp_host_model

// file: test_rs232_host_serial_port.sv
// Purpose: self-checking bench for the serial host port
// Assumes: 115200 baud in traffic, 5-cycle tick
// Notes: table of formats first, flow and break cases after
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; $display("ERROR %0t: mismatch", $time); end end
module test_rs232_host_serial_port;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BIT_CYC = 80;
    typedef struct packed {
        rhsp_pkg::rhsp_fmt_t fmt;
        logic [7:0] ch;
        logic [9:0] frame;
    } rhsp_row_t;
    rhsp_row_t rows [6] = '{'{rhsp_pkg::FMT_NONE8, 8'hA5, 10'h34A}, '{rhsp_pkg::FMT_EVEN7, 8'h35, 10'h26A},
        '{rhsp_pkg::FMT_ODD7, 8'h35, 10'h36A}, '{rhsp_pkg::FMT_EVEN7, 8'h34, 10'h368},
        '{rhsp_pkg::FMT_ODD7, 8'h34, 10'h268}, '{rhsp_pkg::FMT_NONE8, 8'h01, 10'h202}};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, abort_seen = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, rxd, txd, dsr, cts, dtr, rts, serial_selected, keys_locked, abort_pulse;
    logic [9:0] f;
    int fails = 0, n_checks = 0;
    always #50 pclk = ~pclk;
    always @(posedge pclk) if (abort_pulse === 1'b1) abort_seen <= 1'b1;
    rhsp_port i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .rxd, .txd, .dsr, .cts, .dtr, .rts, .serial_selected, .keys_locked, .abort_pulse);
    rhsp_host_model #(.BIT_CYC(BIT_CYC)) i_host (.pclk, .presetn, .txd, .rxd, .dsr, .cts);
    // =========================================
    // tasks
    task automatic end_of_test(input logic hung = 1'b0);
        fails += int'(hung);
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge pclk);
        if (pready !== 1'b1) end_of_test(1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_frame();
        int n;
        for (n = 0; n < 3000 && i_host.got_q.size() == 0; n++) @(posedge pclk);
        if (i_host.got_q.size() == 0) end_of_test(1'b1);
        f = i_host.got_q.pop_front();
    endtask
    // =========================================
    // main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK(dtr, 1'b1)
        `CHK(txd, 1'b1)
        `CHK(serial_selected, 1'b0)
        apb(1'b0, rhsp_pkg::ADDR_CTRL, 32'h0);
        `CHK(q, 32'h0000_0108)
        foreach (rows[i]) begin
            apb(1'b1, rhsp_pkg::ADDR_CTRL, 32'h9 | (32'(rows[i].fmt) << rhsp_pkg::CTRL_FMT_LSB));
            apb(1'b1, rhsp_pkg::ADDR_TXD, {24'h0, rows[i].ch});
            wait_frame();
            `CHK(f, rows[i].frame)
            i_host.send(rows[i].frame);
            apb(1'b0, rhsp_pkg::ADDR_RXD, 32'h0);
            `CHK(q[8:0], 9'h100 | rows[i].ch)
        end
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, rhsp_pkg::ADDR_CTRL, i ? 32'h309 : 32'h109);
            if (i) i_host.cts <= 1'b0;
            else i_host.dsr <= 1'b0;
            repeat (4) @(posedge pclk);
            apb(1'b1, rhsp_pkg::ADDR_TXD, 32'h5A);
            repeat (1600) @(posedge pclk);
            `CHK(i_host.got_q.size(), 0)
            i_host.dsr <= 1'b1;
            i_host.cts <= 1'b1;
            wait_frame();
            `CHK(f, 10'h2B4)
        end
        apb(1'b1, rhsp_pkg::ADDR_CTRL, 32'h409);
        i_host.send(10'h226);
        apb(1'b1, rhsp_pkg::ADDR_TXD, 32'h42);
        repeat (1600) @(posedge pclk);
        `CHK(i_host.got_q.size(), 0)
        apb(1'b0, rhsp_pkg::ADDR_RXD, 32'h0);
        `CHK(q[8], 1'b0)
        i_host.send(10'h222);
        wait_frame();
        `CHK(f, 10'h284)
        apb(1'b1, rhsp_pkg::ADDR_CTRL, 32'h109);
        i_host.dsr <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b1, rhsp_pkg::ADDR_TXD, 32'h77);
        apb(1'b1, rhsp_pkg::ADDR_TXD, 32'h78);
        i_host.send(10'h000);
        repeat (4) @(posedge pclk);
        `CHK(abort_seen, 1'b1)
        apb(1'b0, rhsp_pkg::ADDR_STAT, 32'h0);
        `CHK(q[5], 1'b1)
        i_host.dsr <= 1'b1;
        repeat (1600) @(posedge pclk);
        `CHK(i_host.got_q.size(), 0)
        apb(1'b1, rhsp_pkg::ADDR_CTRL, 32'h209);
        repeat (3) @(posedge pclk);
        `CHK(dtr, 1'b0)
        `CHK(rts, 1'b1)
        apb(1'b1, rhsp_pkg::ADDR_CTRL, 32'h1209);
        apb(1'b1, rhsp_pkg::ADDR_CMD, 32'h2);
        repeat (3) @(posedge pclk);
        `CHK(dtr, 1'b1)
        `CHK(serial_selected, 1'b1)
        `CHK(keys_locked, 1'b1)
        apb(1'b1, rhsp_pkg::ADDR_CMD, 32'h3);
        repeat (3) @(posedge pclk);
        `CHK(keys_locked, 1'b0)
        apb(1'b0, 8'h20, 32'h0);
        `CHK(err, 1'b1)
        `CHK(q, 32'h0)
        end_of_test();
    end
endmodule // test_rs232_host_serial_port
